// ==== core/ccr_cfg.svh ====
// offsets, field positions, reset values and timing counts of the charger bank
`ifndef CCR_CFG_SVH
`define CCR_CFG_SVH

// register offsets
`define CCR_ADDR_LIMIT      8'h01
`define CCR_ADDR_VOLT       8'h02
`define CCR_ADDR_CURR       8'h03

// reset values
`define CCR_RST_LIMIT       8'hac
`define CCR_RST_VOLT        8'h8f
`define CCR_RST_CURR        8'h00

// field positions of the limit and control register
`define CCR_BIT_SOFT_RST    7
`define CCR_INLIM_MSB       6
`define CCR_INLIM_LSB       4
`define CCR_BIT_STAT_EN     3
`define CCR_BIT_TERM_EN     2
`define CCR_BIT_CHG_DIS     1
`define CCR_BIT_STANDBY     0

// field positions of the voltage and current registers
`define CCR_VREG_MSB        7
`define CCR_VREG_LSB        2
`define CCR_CHGC_MSB        7
`define CCR_CHGC_LSB        3
`define CCR_TRMC_MSB        2
`define CCR_TRMC_LSB        0

// input limit and charge current codes with special meaning
`define CCR_INLIM_RESISTOR  3'h6
`define CCR_INLIM_UNLIMITED 3'h7
`define CCR_CHGC_RESISTOR   5'h1f

// analog scaling in mV and mA
`define CCR_VREG_OFFSET_MV  3500
`define CCR_VREG_STEP_MV    20
`define CCR_CHGC_OFFSET_MA  500
`define CCR_CHGC_STEP_MA    50
`define CCR_TRMC_OFFSET_MA  50
`define CCR_TRMC_STEP_MA    25

// watchdog timing
`define CCR_CLK_HZ          50000000
`define CCR_DOG_PERIOD_S    50
`define CCR_MS_PER_S        1000
`define CCR_TICK_CYC        (`CCR_CLK_HZ / `CCR_MS_PER_S)
`define CCR_DOG_TICKS       (`CCR_DOG_PERIOD_S * `CCR_MS_PER_S)

`endif

// ==== core/ccr_pkg.sv ====
// types shared by the charger control register bank
package ccr_pkg;

  // charge controller status reported into the bank
  typedef struct packed {
    logic charging;
    logic done;
    logic fault;
  } ccr_chg_stat_s;

  // settings handed to the analog control loops
  typedef struct packed {
    logic        host_mode;
    logic [2:0]  in_lim_code;
    logic        input_limit_resistor;
    logic        in_lim_unlimited;
    logic        term_enable;
    logic        term_tenth;
    logic        batfet_off;
    logic        converter_off;
    logic [12:0] vreg_mv;
    logic [11:0] chg_cur_ma;
    logic        charge_current_resistor;
    logic [7:0]  trm_cur_ma;
  } ccr_ctrl_s;

endpackage

// ==== core/ccr_watchdog.sv ====
// host watchdog: millisecond divider and expiry counter
`timescale 1ns/1ps
`default_nettype none
`include "ccr_cfg.svh"

module ccr_watchdog #(
  parameter int TICK_CYC = `CCR_TICK_CYC,
  parameter int DOG_TICKS = `CCR_DOG_TICKS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic kick,
  // status
  output logic      expired
);

  logic [31:0] div_q;
  logic [31:0] cnt_q;
  logic        armed_q;
  wire         tick_w = (div_q == 32'(TICK_CYC - 1));
  wire         last_w = tick_w && (cnt_q == 32'(DOG_TICKS - 1));

  // divider gives a one-cycle enable each millisecond
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= 32'h0;
    else if (kick || tick_w)
      div_q <= 32'h0;
    else
      div_q <= div_q + 32'h1;
  end

  // timer stays idle until the first write, stops after expiry
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q   <= 32'h0;
      armed_q <= 1'b0;
    end
    else if (kick)
    begin
      cnt_q   <= 32'h0;
      armed_q <= 1'b1;
    end
    else if (armed_q && last_w)
      armed_q <= 1'b0;
    else if (armed_q && tick_w)
      cnt_q <= cnt_q + 32'h1;
  end

  assign expired = armed_q && last_w && !kick;

endmodule
`default_nettype wire

// ==== core/ccr_regbank.sv ====
// charger control register bank with mode selection and derived settings
`timescale 1ns/1ps
`default_nettype none
`include "ccr_cfg.svh"

// What this block does
// - writing one to the top control bit restores all defaults; write-only.
// - three-bit input limit code, 110 external resistor, 111 unlimited clamp.
// - host mode uses register limit; standalone mode uses the resistor.
// - status enable one drives the pin; zero leaves open drain released.
// - termination bit zero disables termination and hides its indication.
// - charge-disable bit one switches the battery FET off unless the standby bit is also one.
// - standby bit one stops the converter, battery FET stays on.
// - six-bit voltage code, 20 mV steps over 3.5 V offset.
// - low voltage bits read port detection or mode pin levels.
// - five-bit charge code, 50 mA steps over 500 mA offset.
// - all-ones charge code selects resistor-set charge current.
// - three-bit termination code, 25 mA steps over 50 mA offset.
// - in resistor charge mode termination is a tenth of charge current.
// - any bus write restarts the watchdog; expiry reloads defaults.
module ccr_regbank
  import ccr_pkg::*;
#(
  parameter bit PIN_STRAP = 1'b0,
  parameter int TICK_CYC  = `CCR_TICK_CYC,
  parameter int DOG_TICKS = `CCR_DOG_TICKS
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // register access from the serial front end
  input  wire logic          wr_en,
  input  wire logic          rd_en,
  input  wire logic [7:0]    addr,
  input  wire logic [7:0]    wdata,
  output logic [7:0]         rdata,
  // detection and strap inputs
  input  wire logic [1:0]    port_detect_result,
  input  wire logic          mode_pin_high,
  input  wire logic          mode_pin_low,
  // charge controller status and pin request
  input  var  ccr_chg_stat_s chg_stat,
  input  wire logic          stat_req,
  // status pin, open drain
  input  wire logic          stat_pin_i,
  output logic               stat_pin_o,
  output logic               stat_pin_oe,
  // settings and indications
  output ccr_ctrl_s          ctrl,
  output logic               term_done_ind
);

  logic [7:0] regs_q [1:3];
  logic [7:0] rdata_q;
  logic       host_mode_q;
  ccr_ctrl_s  ctrl_q;
  logic       dog_expired;

  // all checks below share the bank clock and its reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // access decode
  wire        wr_limit_w = wr_en && (addr == `CCR_ADDR_LIMIT);
  wire        soft_rst_w = wr_limit_w && wdata[`CCR_BIT_SOFT_RST];
  wire        reload_w   = soft_rst_w || (dog_expired && !wr_en);

  // restart on every bus write, mapped or not
  // watchdog restart
  ccr_watchdog #(
    .TICK_CYC (TICK_CYC),
    .DOG_TICKS (DOG_TICKS)
  ) u_dog (
    .clk     (clk),
    .rst_n   (rst_n),
    .kick    (wr_en),
    .expired (dog_expired)
  );

  // register storage; a soft reset write ignores its other bits
  genvar gi;
  generate
    for (gi = 1; gi <= 3; gi++)
    begin : g_reg
      // constant default keeps the async reset branch free of logic
      localparam logic [7:0] RST_V = (gi == 1) ? `CCR_RST_LIMIT :
                                     (gi == 2) ? `CCR_RST_VOLT  :
                                                 `CCR_RST_CURR;
      wire hit_w = wr_en && (addr == 8'(gi)) && !soft_rst_w;
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          regs_q[gi] <= RST_V;
        else if (reload_w)
          regs_q[gi] <= RST_V;
        else if (hit_w)
          regs_q[gi] <= wdata;
      end
    end
  endgenerate

  // host mode: a write wins over an expiry in the same cycle
  // mode selection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      host_mode_q <= 1'b0;
    else if (wr_en)
      host_mode_q <= 1'b1;
    else if (dog_expired)
      host_mode_q <= 1'b0;
  end

  // field extraction
  wire [2:0] in_lim_w  = regs_q[1][`CCR_INLIM_MSB:`CCR_INLIM_LSB];
  wire       stat_en   = regs_q[1][`CCR_BIT_STAT_EN];
  wire       term_en   = regs_q[1][`CCR_BIT_TERM_EN];
  wire       chg_dis   = regs_q[1][`CCR_BIT_CHG_DIS];
  wire       standby   = regs_q[1][`CCR_BIT_STANDBY];
  wire [5:0] vreg_w    = regs_q[2][`CCR_VREG_MSB:`CCR_VREG_LSB];
  wire [4:0] chg_cur_w = regs_q[3][`CCR_CHGC_MSB:`CCR_CHGC_LSB];
  wire [2:0] trm_cur_w = regs_q[3][`CCR_TRMC_MSB:`CCR_TRMC_LSB];

  wire [1:0] det_w = PIN_STRAP ? {mode_pin_high, mode_pin_low}
                               : port_detect_result;

  // read mux; soft reset bit always reads zero, unmapped reads zero
  // write-only bit
  wire [7:0] rd_mux_w =
    (addr == `CCR_ADDR_LIMIT) ? {1'b0, regs_q[1][6:0]} :
    (addr == `CCR_ADDR_VOLT)  ? {regs_q[2][7:2], det_w} :
    (addr == `CCR_ADDR_CURR)  ? regs_q[3] : 8'h00;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (rd_en)
      rdata_q <= rd_mux_w;
  end
  assign rdata = rdata_q;

  // derived settings
  // input limit decode
  wire       in_lim_res_w = !host_mode_q
                         || (in_lim_w == `CCR_INLIM_RESISTOR);
  wire       in_lim_unl_w = host_mode_q
                         && (in_lim_w == `CCR_INLIM_UNLIMITED);
  wire       chg_res_w = (chg_cur_w == `CCR_CHGC_RESISTOR);
  wire [12:0] vreg_mv_w = 13'(`CCR_VREG_OFFSET_MV)
                        + 13'(vreg_w) * 13'(`CCR_VREG_STEP_MV);
  wire [11:0] chg_ma_w = 12'(`CCR_CHGC_OFFSET_MA)
                       + 12'(chg_cur_w) * 12'(`CCR_CHGC_STEP_MA);
  wire [7:0] trm_ma_w = 8'(`CCR_TRMC_OFFSET_MA)
                      + 8'(trm_cur_w) * 8'(`CCR_TRMC_STEP_MA);

  // settings are registered so the loops never see a decode glitch
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= '0;
    else
    begin
      ctrl_q.host_mode      <= host_mode_q;
      ctrl_q.in_lim_code    <= in_lim_w;
      ctrl_q.input_limit_resistor <= in_lim_res_w;
      ctrl_q.in_lim_unlimited <= in_lim_unl_w;
      ctrl_q.term_enable    <= term_en;
      ctrl_q.term_tenth     <= chg_res_w;
      // battery FET off, standby keeps it on
      ctrl_q.batfet_off     <= chg_dis && !standby;
      ctrl_q.converter_off  <= standby;
      ctrl_q.vreg_mv        <= vreg_mv_w;
      ctrl_q.chg_cur_ma     <= chg_ma_w;
      ctrl_q.charge_current_resistor <= chg_res_w;
      ctrl_q.trm_cur_ma     <= trm_ma_w;
    end
  end
  assign ctrl = ctrl_q;

  assign term_done_ind = chg_stat.done && term_en;

  // open drain: pin only pulled low, never driven high
  // status pin gate
  assign stat_pin_o  = 1'b0;
  assign stat_pin_oe = stat_en && stat_req;

  // checks
  sequence s_soft_rst;
    wr_en && (addr == `CCR_ADDR_LIMIT) && wdata[`CCR_BIT_SOFT_RST];
  endsequence

  property p_soft_rst;
    s_soft_rst |=> (regs_q[1] == `CCR_RST_LIMIT)
      && (regs_q[2] == `CCR_RST_VOLT) && (regs_q[3] == `CCR_RST_CURR);
  endproperty
  a_soft_rst: assert property (p_soft_rst)
    else $error("soft reset did not restore defaults");

  property p_rd_zero;
    rd_en && (addr == `CCR_ADDR_LIMIT) |=> !rdata[`CCR_BIT_SOFT_RST];
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("soft reset bit read back as one");

  property p_in_lim;
    1'b1 |=> ctrl.input_limit_resistor == ($past(!host_mode_q)
      || ($past(in_lim_w) == `CCR_INLIM_RESISTOR));
  endproperty
  a_in_lim: assert property (p_in_lim)
    else $error("input limit source mismatch");

  property p_host;
    wr_en |=> host_mode_q ##1 ctrl.host_mode;
  endproperty
  a_host: assert property (p_host)
    else $error("write did not enter host mode");

  // a plain write that clears the enable releases the pin next cycle
  property p_stat;
    wr_limit_w && !wdata[`CCR_BIT_SOFT_RST] && !wdata[`CCR_BIT_STAT_EN]
      |=> !stat_pin_oe && !stat_pin_o;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status pin pulled while disabled");

  property p_term;
    wr_limit_w && !wdata[`CCR_BIT_SOFT_RST] && !wdata[`CCR_BIT_TERM_EN]
      |=> !term_done_ind ##1 !ctrl.term_enable;
  endproperty
  a_term: assert property (p_term)
    else $error("termination shown while disabled");

  property p_batfet;
    chg_dis && !standby |=> ctrl.batfet_off;
  endproperty
  a_batfet: assert property (p_batfet)
    else $error("battery FET not switched off");

  property p_standby;
    standby |=> ctrl.converter_off && !ctrl.batfet_off;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby settings wrong");

  property p_vreg;
    1'b1 |=> ctrl.vreg_mv == 13'(3500) + 13'($past(vreg_w)) * 13'(20);
  endproperty
  a_vreg: assert property (p_vreg)
    else $error("battery voltage scaling wrong");

  property p_detect;
    rd_en && (addr == `CCR_ADDR_VOLT) |=> rdata[1:0] == $past(det_w);
  endproperty
  a_detect: assert property (p_detect)
    else $error("detection bits wrong");

  property p_chg_cur;
    1'b1 |=> ctrl.chg_cur_ma
      == 12'(500) + 12'($past(chg_cur_w)) * 12'(50);
  endproperty
  a_chg_cur: assert property (p_chg_cur)
    else $error("charge current scaling wrong");

  property p_ext;
    (chg_cur_w == 5'h1f)
      |=> ctrl.charge_current_resistor && ctrl.term_tenth;
  endproperty
  a_ext: assert property (p_ext)
    else $error("resistor charge mode not entered");

  property p_trm_cur;
    1'b1 |=> ctrl.trm_cur_ma == 8'(50) + 8'($past(trm_cur_w)) * 8'(25);
  endproperty
  a_trm_cur: assert property (p_trm_cur)
    else $error("termination current scaling wrong");

  property p_dog;
    dog_expired && !wr_en |=> !host_mode_q
      && (regs_q[3] == `CCR_RST_CURR);
  endproperty
  a_dog: assert property (p_dog)
    else $error("expiry did not reload defaults");

endmodule
`default_nettype wire

// ==== tb/ccr_host_model.sv ====
// host side model that issues byte writes and reads on the register port
`timescale 1ns/1ps
`default_nettype none

module ccr_host_model (
  // clock
  input  wire logic       clk,
  // register port toward the bank
  output logic            wr_en,
  output logic            rd_en,
  output logic [7:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata
);
  // idle port at time zero
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end

  // released lines show the inverse of the last value, never a stale copy
  // host keeps writing
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    addr  = ~a;
    wdata = ~d;
  endtask

  // read data is valid one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    addr  = a;
    @(posedge clk);
    #1;
    q     = rdata;
    rd_en = 1'b0;
    addr  = ~a;
  endtask
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the charger control register bank
`timescale 1ns/1ps
`default_nettype none
`include "ccr_cfg.svh"

module tb_top;
  import ccr_pkg::*;
  // clock, reset and register port
  logic          clk;
  logic          rst_n;
  logic          wr_en;
  logic          rd_en;
  logic [7:0]    addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  logic [7:0]    rdata_s;
  // side inputs and outputs
  logic [1:0]    det;
  logic          pin_hi;
  logic          pin_lo;
  ccr_chg_stat_s chg_stat;
  logic          stat_req;
  logic          pin_i;
  logic          pin_o;
  logic          pin_oe;
  ccr_ctrl_s     ctrl;
  logic          done_ind;
  // reference model state and counters
  int            n_mismatch = 0;
  int            check_count = 0;
  int            seed = 16;
  int            k;
  logic [7:0]    r [4];
  logic          host;
  logic [7:0]    got;
  logic [7:0]    d;

  // short watchdog so expiry fits in the run
  ccr_regbank #(.PIN_STRAP(1'b0), .TICK_CYC(4), .DOG_TICKS(8)) dut (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .port_detect_result(det),
    .mode_pin_high(pin_hi), .mode_pin_low(pin_lo), .chg_stat(chg_stat),
    .stat_req(stat_req), .stat_pin_i(pin_i), .stat_pin_o(pin_o),
    .stat_pin_oe(pin_oe), .ctrl(ctrl), .term_done_ind(done_ind));

  // strap variant shares the port and reads the mode pins instead
  ccr_regbank #(.PIN_STRAP(1'b1), .TICK_CYC(4), .DOG_TICKS(8)) dut_strap (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata_s), .port_detect_result(det),
    .mode_pin_high(pin_hi), .mode_pin_low(pin_lo), .chg_stat(chg_stat),
    .stat_req(stat_req), .stat_pin_i(pin_i), .stat_pin_o(),
    .stat_pin_oe(), .ctrl(), .term_done_ind());

  ccr_host_model u_host (
    .clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata));

  // one comparison, counted
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // model of what a read returns; unmapped places read zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == `CCR_ADDR_LIMIT)
      return {1'b0, r[1][6:0]};
    if (a == `CCR_ADDR_VOLT)
      return {r[2][7:2], det};
    if (a == `CCR_ADDR_CURR)
      return r[3];
    return 8'h00;
  endfunction

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] es;
    u_host.rd(a, got);
    es = (a == `CCR_ADDR_VOLT) ? {r[2][7:2], pin_hi, pin_lo} : exp_rd(a);
    chk("rdata", exp_rd(a), got);
    chk("rdata_strap", es, rdata_s);
  endtask

  task automatic load_defaults();
    r[1] = `CCR_RST_LIMIT;
    r[2] = `CCR_RST_VOLT;
    r[3] = `CCR_RST_CURR;
  endtask

  // decoded settings; resistor charge mode leaves the coded currents unused
  task automatic chk_ctrl();
    logic [2:0] il;
    logic [4:0] ic;
    il = r[1][6:4];
    ic = r[3][7:3];
    chk("host_mode", host, ctrl.host_mode);
    chk("in_lim_code", il, ctrl.in_lim_code);
    chk("lim_res", !host || il == 3'h6, ctrl.input_limit_resistor);
    chk("lim_unl", host && il == 3'h7, ctrl.in_lim_unlimited);
    chk("term_enable", r[1][2], ctrl.term_enable);
    chk("converter_off", r[1][0], ctrl.converter_off);
    chk("batfet_off", r[1][1] & ~r[1][0], ctrl.batfet_off);
    chk("vreg_mv", 3500 + 20 * r[2][7:2], ctrl.vreg_mv);
    chk("chg_res", ic == 5'h1f, ctrl.charge_current_resistor);
    chk("term_tenth", ic == 5'h1f, ctrl.term_tenth);
    if (ic != 5'h1f)
    begin
      chk("chg_cur_ma", 500 + 50 * ic, ctrl.chg_cur_ma);
      chk("trm_cur_ma", 50 + 25 * r[3][2:0], ctrl.trm_cur_ma);
    end
    chk("stat_pin_oe", r[1][3] & stat_req, pin_oe);
    chk("stat_pin_o", 0, pin_o);
    chk("term_done_ind", r[1][2] & chg_stat.done, done_ind);
  endtask

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // main sequence
  initial
  begin
    rst_n    = 1'b0;
    det      = 2'h2;
    pin_hi   = 1'b1;
    pin_lo   = 1'b0;
    chg_stat = 3'h2;
    stat_req = 1'b1;
    pin_i    = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    load_defaults();
    host = 1'b0;
    @(posedge clk);
    #1;
    chk_ctrl();
    for (k = 0; k < 5; k++)
      rd_chk(k[7:0]);
    // an unmapped write is dropped but still enters host mode
    u_host.wr(8'h05, 8'h5a);
    host = 1'b1;
    rd_chk(8'h05);
    chk_ctrl();
    // every input limit code, random fields and side inputs
    for (k = 0; k < 24; k++)
    begin
      d = 8'($random(seed));
      r[1] = {1'b0, k[2:0], d[3:0]};
      u_host.wr(`CCR_ADDR_LIMIT, r[1]);
      r[2] = 8'($random(seed));
      u_host.wr(`CCR_ADDR_VOLT, r[2]);
      r[3] = 8'($random(seed));
      if (k[1:0] == 2'h0)
        r[3][7:3] = 5'h1f;
      u_host.wr(`CCR_ADDR_CURR, r[3]);
      d = 8'($random(seed));
      det      = d[1:0];
      pin_hi   = d[2];
      pin_lo   = d[3];
      chg_stat = d[6:4];
      stat_req = d[7];
      pin_i    = d[5];
      rd_chk(`CCR_ADDR_LIMIT);
      rd_chk(`CCR_ADDR_VOLT);
      rd_chk(`CCR_ADDR_CURR);
      chk_ctrl();
    end
    // soft reset drops the other bits of the same byte
    u_host.wr(`CCR_ADDR_LIMIT, 8'hff);
    load_defaults();
    for (k = 1; k < 4; k++)
      rd_chk(k[7:0]);
    chk_ctrl();
    // a write inside the period keeps host mode
    repeat (20) @(posedge clk);
    u_host.wr(`CCR_ADDR_CURR, 8'h2a);
    r[3] = 8'h2a;
    repeat (20) @(posedge clk);
    #1;
    chk("host_mode", 1, ctrl.host_mode);
    // expiry falls back to standalone with defaults
    for (k = 0; k < 60 && ctrl.host_mode !== 1'b0; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (k == 60)
    begin
      n_mismatch++;
      $display("[ERR] watchdog expiry expected 1 seen 0");
    end
    else
    begin
      host = 1'b0;
      load_defaults();
      chk_ctrl();
      rd_chk(`CCR_ADDR_CURR);
    end
    end_of_test();
  end
endmodule

`default_nettype wire
